/* verilog/switch_to_vme_bridge.sv */
// switch message to vme master bridge with mapping table
//
// The address map and strobed register access were left to the implementer.
`default_nettype none

module switch_to_vme_bridge
  import bridge_pkg::*;
(
  // clock, reset, enable
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  ce_i,
  // register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  // switch port 0
  input  wire logic [7:0]            port0_id_i,
  input  wire logic                  msg0_valid_i,
  input  wire sw_msg_t               msg0_i,
  output logic                       msg0_ready_o,
  // switch port 1 (optional)
  input  wire logic                  port1_present_i,
  input  wire logic [7:0]            port1_id_i,
  input  wire logic                  msg1_valid_i,
  input  wire sw_msg_t               msg1_i,
  output logic                       msg1_ready_o,
  // read answers toward the switch
  output logic                       rsp_valid_o,
  output sw_rsp_t                    rsp_o,
  output logic                       rsp_port_o,
  input  wire logic                  rsp_ready_i,
  // vme master
  output logic [31:0]                vme_addr_o,
  output logic [5:0]                 vme_am_o,
  output logic                       vme_as_o,
  output logic                       vme_ds_o,
  output logic                       vme_write_o,
  output logic                       vme_blt_o,
  output logic [31:0]                vme_data_o,
  output logic                       vme_data_oe_o,
  input  wire logic [31:0]           vme_data_i,
  input  wire logic                  vme_dtack_i
);

  function automatic logic is_map_addr(input logic [REG_ADDR_W-1:0] a);
    is_map_addr = (a < REG_ADDR_W'(MAP_ENTRIES));
  endfunction

  // pin synchronisers: three stages, accept a level once stages two and three agree
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_filt;
  assign pin_raw = {vme_dtack_i, port1_present_i};

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic filt_reg;
      always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
          s1_reg   <= 1'b0;
          s2_reg   <= 1'b0;
          s3_reg   <= 1'b0;
          filt_reg <= 1'b0;
        end else if (ce_i) begin
          s1_reg <= pin_raw[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            filt_reg <= s3_reg;
          end
        end
      end
      assign pin_filt[g] = filt_reg;
    end
  endgenerate

  logic dtack_seen;
  logic port1_ok;
  assign dtack_seen = pin_filt[1];
  assign port1_ok   = pin_filt[0];

  // state
  bridge_state_t state_reg;
  map_entry_t    map_reg [MAP_ENTRIES];
  logic [1:0]    ctrl_reg;
  logic [15:0]   lower_address_holder_reg;
  logic [15:0]   upper_address_holder_reg;
  logic [5:0]    am_reg;
  logic          read_reg;
  logic          blk_reg;
  logic          active_port_reg;
  logic [7:0]    dest_reg;
  logic [BEAT_W-1:0] beats_left_reg;
  logic [31:0]   wdata_reg;
  logic          as_reg;
  logic          ds_reg;
  sw_rsp_t       rsp_reg;
  logic [31:0]   rdata_reg;

  logic slave_sequencing_flag;
  logic address_step_flag;
  assign slave_sequencing_flag = ctrl_reg[CTRL_SEQ_BIT];
  assign address_step_flag     = ctrl_reg[CTRL_STEP_BIT];

  // message acceptance; port 0 wins a tie since it is always cabled
  logic    take0;
  logic    take1;
  logic    fetch_valid;
  sw_msg_t hdr;
  sw_msg_t fetch_msg;
  logic [7:0] cur_port_id;

  assign take0 = (state_reg == ST_IDLE) && msg0_valid_i;
  assign take1 = (state_reg == ST_IDLE) && !msg0_valid_i && msg1_valid_i && port1_ok;
  assign hdr   = take0 ? msg0_i : msg1_i;
  assign fetch_valid = active_port_reg ? msg1_valid_i : msg0_valid_i;
  assign fetch_msg   = active_port_reg ? msg1_i : msg0_i;
  assign cur_port_id = active_port_reg ? port1_id_i : port0_id_i;

  assign msg0_ready_o = ce_i && (take0 || ((state_reg == ST_FETCH) && !active_port_reg));
  assign msg1_ready_o = ce_i && (take1 || ((state_reg == ST_FETCH) && active_port_reg));

  logic last_beat;
  assign last_beat = (beats_left_reg == '0);

  // sequencer and vme strobes
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state_reg                <= ST_IDLE;
      lower_address_holder_reg <= 16'h0000;
      upper_address_holder_reg <= 16'h0000;
      am_reg                   <= 6'h00;
      read_reg                 <= 1'b1;
      blk_reg                  <= 1'b0;
      active_port_reg          <= 1'b0;
      dest_reg                 <= 8'h00;
      beats_left_reg           <= '0;
      wdata_reg                <= 32'h0000_0000;
      as_reg                   <= 1'b0;
      ds_reg                   <= 1'b0;
      rsp_reg                  <= '0;
    end else if (ce_i) begin
      case (state_reg)
        ST_IDLE: begin
          if (take0 || take1) begin
            upper_address_holder_reg <= map_reg[hdr.map_idx].upper;
            am_reg                   <= map_reg[hdr.map_idx].am;
            lower_address_holder_reg <= hdr.offset;
            read_reg                 <= hdr.is_read;
            blk_reg                  <= slave_sequencing_flag && (hdr.beats_m1 != '0);
            active_port_reg          <= take1;
            dest_reg                 <= hdr.src_node;
            beats_left_reg           <= hdr.beats_m1;
            wdata_reg                <= hdr.data;
            state_reg                <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          // address settles one cycle before the strobe rises
          as_reg    <= 1'b1;
          state_reg <= ST_DATA;
        end
        ST_FETCH: begin
          if (fetch_valid) begin
            wdata_reg <= fetch_msg.data;
            state_reg <= blk_reg ? ST_DATA : ST_ADDR;
          end
        end
        ST_DATA: begin
          if (!ds_reg) begin
            ds_reg <= 1'b1;
          end else if (dtack_seen) begin
            ds_reg <= 1'b0;
            if (read_reg) begin
              rsp_reg.data      <= vme_data_i;
              rsp_reg.dest_node <= dest_reg;
              rsp_reg.port_id   <= cur_port_id;
              rsp_reg.last      <= last_beat;
            end
            state_reg <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // wait for the slave to drop its acknowledge before the next access
          if (!dtack_seen) begin
            if (read_reg) begin
              state_reg <= ST_RESP;
            end else if (last_beat) begin
              as_reg    <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              beats_left_reg <= beats_left_reg - 1'b1;
              if (!blk_reg) begin
                as_reg <= 1'b0;
                if (address_step_flag) begin
                  // 16-bit wrap, upper half untouched; no 256-byte check either
                  lower_address_holder_reg <= lower_address_holder_reg + ADDR_STEP;
                end
              end
              state_reg <= ST_FETCH;
            end
          end
        end
        ST_RESP: begin
          if (rsp_ready_i) begin
            if (last_beat) begin
              as_reg    <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              beats_left_reg <= beats_left_reg - 1'b1;
              if (blk_reg) begin
                state_reg <= ST_DATA;
              end else begin
                as_reg <= 1'b0;
                if (address_step_flag) begin
                  lower_address_holder_reg <= lower_address_holder_reg + ADDR_STEP;
                end
                state_reg <= ST_ADDR;
              end
            end
          end
        end
        default: begin
          as_reg    <= 1'b0;
          ds_reg    <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // mapping table writes
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < MAP_ENTRIES; i++) begin
        map_reg[i] <= '0;
      end
    end else if (ce_i && reg_wr_i && is_map_addr(reg_addr_i)) begin
      map_reg[reg_addr_i[MAP_IDX_W-1:0]].upper <= reg_wdata_i[MAP_UPPER_LSB +: 16];
      map_reg[reg_addr_i[MAP_IDX_W-1:0]].am    <= reg_wdata_i[MAP_AM_LSB +: 6];
    end
  end

  // control bits
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ce_i && reg_wr_i && (reg_addr_i == CTRL_OFFSET)) begin
      ctrl_reg <= reg_wdata_i[1:0];
    end
  end

  // read data, valid only in the cycle after the read strobe
  logic [31:0] rd_next;
  always_comb begin
    rd_next = 32'h0000_0000;
    if (is_map_addr(reg_addr_i)) begin
      rd_next[MAP_UPPER_LSB +: 16] = map_reg[reg_addr_i[MAP_IDX_W-1:0]].upper;
      rd_next[MAP_AM_LSB +: 6]     = map_reg[reg_addr_i[MAP_IDX_W-1:0]].am;
    end else begin
      case (reg_addr_i)
        CTRL_OFFSET: begin
          rd_next[1:0] = ctrl_reg;
        end
        STATUS_OFFSET: begin
          rd_next[STAT_BUSY_BIT]     = (state_reg != ST_IDLE);
          rd_next[STAT_P1_BIT]       = port1_ok;
          rd_next[STAT_PORT_BIT]     = active_port_reg;
          rd_next[STAT_ID0_LSB +: 8] = port0_id_i;
          rd_next[STAT_ID1_LSB +: 8] = port1_id_i;
        end
        LOWER_OFFSET: begin
          rd_next[15:0] = lower_address_holder_reg;
        end
        UPPER_OFFSET: begin
          rd_next[15:0] = upper_address_holder_reg;
        end
        default: begin
          rd_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_reg <= reg_rd_i ? rd_next : 32'h0000_0000;
    end
  end

  // outputs; only master-side vme signals exist, no slave decode
  assign reg_rdata_o   = rdata_reg;
  assign rsp_valid_o   = (state_reg == ST_RESP);
  assign rsp_o         = rsp_reg;
  assign rsp_port_o    = active_port_reg;
  assign vme_addr_o    = {upper_address_holder_reg, lower_address_holder_reg};
  assign vme_am_o      = am_reg;
  assign vme_as_o      = as_reg;
  assign vme_ds_o      = ds_reg;
  assign vme_write_o   = !read_reg;
  assign vme_blt_o     = blk_reg;
  assign vme_data_o    = wdata_reg;
  assign vme_data_oe_o = !read_reg && as_reg;

endmodule // switch_to_vme_bridge

`default_nettype wire

/* verilog/bridge_pkg.sv */
// shared constants and types for the switch-to-vme bridge
// Function
// - upper 16 address bits come from upper holder; lower steps never carry upward.
// - bridge passes 256-byte boundary crossings unchecked; requester avoids them.
// - each switch message address is translated through the internal mapping table.
// - translation yields 32-bit vme address plus six modifier bits, both driven.
// - a write finishes once address, modifiers and data complete the bus access.
// - read data from the slave returns through the switch to the requester.
// - bridge is only a vme master; it never answers vme-side accesses.
// - data moves either direction; vme-to-vme copies do not pass through the bridge.
// - bridge identified by attached switch port address 0..255, may change.
// - two switch ports, port 0 always present, port 1 optional; both usable.
// - with slave sequencing set, block messages run as vme block transfers.
// - self-sequenced accesses step the address when step flag set, else repeat.
`default_nettype none

package bridge_pkg;

  localparam int MAP_IDX_W   = 6;
  localparam int MAP_ENTRIES = 64;
  localparam int REG_ADDR_W  = 7;
  localparam int BEAT_W      = 6;

  // register map on the plain port; map entries sit at indices 0..63
  localparam logic [REG_ADDR_W-1:0] CTRL_OFFSET   = 7'h40;
  localparam logic [REG_ADDR_W-1:0] STATUS_OFFSET = 7'h41;
  localparam logic [REG_ADDR_W-1:0] LOWER_OFFSET  = 7'h42;
  localparam logic [REG_ADDR_W-1:0] UPPER_OFFSET  = 7'h43;

  localparam int CTRL_SEQ_BIT  = 0;
  localparam int CTRL_STEP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  localparam int MAP_UPPER_LSB = 0;
  localparam int MAP_AM_LSB    = 16;

  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_P1_BIT    = 1;
  localparam int STAT_PORT_BIT  = 2;
  localparam int STAT_ID0_LSB   = 8;
  localparam int STAT_ID1_LSB   = 16;

  localparam logic [15:0] ADDR_STEP = 16'h0004;
  localparam int PIN_COUNT = 2;

  typedef struct packed {
    logic [7:0]           src_node;
    logic                 is_read;
    logic [MAP_IDX_W-1:0] map_idx;
    logic [15:0]          offset;
    logic [BEAT_W-1:0]    beats_m1;
    logic [31:0]          data;
  } sw_msg_t;

  typedef struct packed {
    logic [7:0]  dest_node;
    logic [7:0]  port_id;
    logic        last;
    logic [31:0] data;
  } sw_rsp_t;

  typedef struct packed {
    logic [5:0]  am;
    logic [15:0] upper;
  } map_entry_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_FETCH,
    ST_DATA,
    ST_RELEASE,
    ST_RESP
  } bridge_state_t;

endpackage

`default_nettype wire

/* verif/vme_slave_model.sv */
// vme slave responder with a programmable acknowledge delay
`default_nettype none
module vme_slave_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // master side
  input  wire logic [31:0] addr_i,
  input  wire logic        ds_i,
  input  wire logic [1:0]  dly_i,
  // slave answer
  output logic             dtack_o,
  output logic [31:0]      data_o
);
  logic [1:0] cnt_reg;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= 2'h0;
      dtack_o <= 1'h0;
      data_o  <= 32'h0;
    end else if (ds_i && !dtack_o) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg == dly_i) begin
        dtack_o <= 1'h1;
        data_o  <= ~addr_i;
      end
    end else if (!ds_i) begin
      cnt_reg <= 2'h0;
      dtack_o <= 1'h0;
      // released lines wander so a stale value never passes
      data_o  <= ~data_o;
    end
  end
endmodule // vme_slave_model
`default_nettype wire

/* verif/bridge_asserts.sv */
// port checker for the switch-to-vme bridge
`default_nettype none
module bridge_asserts
  import bridge_pkg::*;
(
  // watched ports
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  input wire logic        msg0_ready_o,
  input wire logic        msg1_ready_o,
  input wire logic        port1_present_i,
  input wire logic        rsp_valid_o,
  input wire logic        rsp_ready_i,
  input wire sw_rsp_t     rsp_o,
  input wire logic [31:0] vme_addr_o,
  input wire logic [5:0]  vme_am_o,
  input wire logic        vme_as_o,
  input wire logic        vme_ds_o,
  input wire logic        vme_write_o,
  input wire logic        vme_blt_o,
  input wire logic        vme_data_oe_o,
  input wire logic        vme_dtack_i
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_ds_as; vme_ds_o |-> vme_as_o; endproperty
  a_ds_as: assert property (p_ds_as) else $error("ds without as");
  property p_oe; vme_data_oe_o |-> vme_as_o && vme_write_o; endproperty
  a_oe: assert property (p_oe) else $error("data driven outside write");
  property p_hold;
    vme_as_o && $past(vme_as_o) |-> $stable(vme_addr_o) && $stable(vme_am_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved under as");
  property p_drop; vme_ds_o && vme_dtack_i |-> ##[1:6] !vme_ds_o; endproperty
  a_drop: assert property (p_drop) else $error("ds held after ack");
  property p_next; $rose(vme_ds_o) |-> !vme_dtack_i && !$past(vme_dtack_i); endproperty
  a_next: assert property (p_next) else $error("beat before ack low");
  property p_rsp;
    rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_o);
  endproperty
  a_rsp: assert property (p_rsp) else $error("answer dropped");
  // a block write keeps as high while it fetches the next data beat, so that case is exempt
  property p_busy;
    rsp_valid_o || vme_ds_o || (vme_as_o && !(vme_write_o && vme_blt_o))
      |-> !msg0_ready_o && !msg1_ready_o;
  endproperty
  a_busy: assert property (p_busy) else $error("accept while busy");
  property p_p1; !port1_present_i [*8] |-> !msg1_ready_o; endproperty
  a_p1: assert property (p_p1) else $error("absent port accepts");
endmodule // bridge_asserts
bind switch_to_vme_bridge bridge_asserts u_bridge_asserts (.*);
`default_nettype wire

/* verif/testbench.sv */
// randomised self-checking bench for the switch-to-vme bridge
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bridge_pkg::*;
  logic core_clk_i = 0, rstn_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic msg0_valid_i = 0, msg1_valid_i = 0, port1_present_i = 0, rsp_ready_i = 0;
  logic [REG_ADDR_W-1:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, reg_rdata_o, vme_addr_o, vme_data_o, vme_data_i;
  logic [7:0] port0_id_i = '0, port1_id_i = '0;
  sw_msg_t msg0_i = '0, msg1_i = '0;
  sw_rsp_t rsp_o;
  logic [5:0] vme_am_o, ams[4];
  logic [15:0] ups[4], e_up, e_off, e_stp;
  logic msg0_ready_o, msg1_ready_o, rsp_valid_o, rsp_port_o, vme_dtack_i, ds_q = 0;
  logic vme_as_o, vme_ds_o, vme_write_o, vme_blt_o, vme_data_oe_o, e_wr, e_blt;
  logic [1:0] dly = 2'h0;
  logic [31:0] seed = 32'h739005d2, e_base;
  logic [5:0] e_am;
  int err_count, n_compared, cyc, e_k;
  switch_to_vme_bridge u_switch_to_vme_bridge (.*);
  vme_slave_model u_vme_slave_model (.clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(vme_addr_o),
    .ds_i(vme_ds_o), .dly_i(dly), .dtack_o(vme_dtack_i), .data_o(vme_data_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_addr(input int k);
    return {e_up, e_off + e_stp * k[15:0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end
  always @(posedge core_clk_i) begin
    ds_q <= vme_ds_o;
    if (vme_ds_o && !ds_q) begin
      check("vme_addr", vme_addr_o, exp_addr(e_k));
      check("vme_am", vme_am_o, e_am);
      check("vme_mode", {vme_write_o, vme_blt_o}, {e_wr, e_blt});
      if (e_wr) check("vme_data", vme_data_o, e_base + e_k);
      e_k++;
    end
  end
  task automatic reg_wr(input logic [REG_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  task automatic reg_rd(input logic [REG_ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'h0;
    #1 check("reg_rdata", reg_rdata_o, e);
  endtask
  // no local bound: a hang runs into the cycle ceiling and fails the run
  task automatic wait_on(input int sel);
    do begin
      @(posedge core_clk_i);
    end while ((sel == 0 ? msg0_ready_o : sel == 1 ? msg1_ready_o
                                        : rsp_valid_o) !== 1'h1);
  endtask
  task automatic op(input int i);
    sw_msg_t m;
    logic [31:0] r;
    logic p;
    int k;
    r = rnd();
    reg_wr(CTRL_OFFSET, {30'h0, i[1:0]});
    m.src_node = r[7:0];
    m.is_read = r[8];
    m.map_idx = {4'h0, r[10:9]};
    m.beats_m1 = (i < 8) ? 6'h3 : {4'h0, r[12:11]};
    // cases 0..3 start at fffc and only case 2 steps through the lower-half wrap; only case 6 steps across a 256-byte line
    m.offset = (i < 4) ? 16'hfffc : (i < 8) ? 16'h00f8 : {r[27:14], 2'h0};
    p = r[13];
    dly <= r[31:30];
    port0_id_i <= (i == 2) ? 8'hff : r[23:16];
    port1_id_i <= (i == 3) ? 8'h00 : r[31:24];
    e_up = ups[m.map_idx[1:0]];
    e_am = ams[m.map_idx[1:0]];
    e_off = m.offset;
    e_blt = i[0] && m.beats_m1 != 6'h0;
    e_stp = (e_blt || !i[1]) ? 16'h0 : ADDR_STEP;
    e_wr = !m.is_read;
    e_base = rnd();
    e_k = 0;
    for (k = 0; k <= (m.is_read ? 0 : int'(m.beats_m1)); k++) begin
      m.data = e_base + k;
      if (p) msg1_i <= m;
      else msg0_i <= m;
      msg1_valid_i <= p;
      msg0_valid_i <= !p;
      wait_on(p ? 1 : 0);
    end
    msg0_valid_i <= 1'h0;
    msg1_valid_i <= 1'h0;
    for (k = 0; m.is_read && k <= int'(m.beats_m1); k++) begin
      wait_on(2);
      repeat (rnd() % 3) @(posedge core_clk_i);
      check("rsp_head", {rsp_o.dest_node, rsp_o.port_id, rsp_o.last, rsp_port_o},
            {m.src_node, p ? port1_id_i : port0_id_i, k == m.beats_m1, p});
      check("rsp_data", rsp_o.data, ~exp_addr(k));
      rsp_ready_i <= 1'h1;
      @(posedge core_clk_i);
      rsp_ready_i <= 1'h0;
    end
    // idle once every beat has been strobed and the address strobe is down
    while (vme_as_o !== 1'h0 || e_k <= int'(m.beats_m1)) begin
      @(posedge core_clk_i);
    end
    check("beats", e_k, m.beats_m1 + 1);
    reg_rd(UPPER_OFFSET, {16'h0, e_up});
    reg_rd(LOWER_OFFSET, {16'h0, e_off + e_stp * m.beats_m1});
    reg_rd(STATUS_OFFSET, {8'h0, port1_id_i, port0_id_i, 5'h0, p, 2'h2});
  endtask
  initial begin
    logic [31:0] r;
    repeat (4) @(posedge core_clk_i);
    rstn_i <= 1'h1;
    reg_rd(CTRL_OFFSET, {30'h0, CTRL_RESET});
    reg_rd(7'h44, 32'h0);
    reg_wr(7'h7f, 32'hffffffff);
    reg_rd(7'h7f, 32'h0);
    for (int j = 0; j < 4; j++) begin
      r = rnd();
      ups[j] = r[15:0];
      ams[j] = r[21:16];
      reg_wr(7'(j), {10'h0, ams[j], ups[j]});
      reg_rd(7'(j), {10'h0, ams[j], ups[j]});
    end
    // absent port must be ignored even with a message waiting
    msg1_valid_i <= 1'h1;
    repeat (12) @(posedge core_clk_i);
    check("p1_absent", vme_as_o, 1'h0);
    msg1_valid_i <= 1'h0;
    port1_present_i <= 1'h1;
    repeat (8) @(posedge core_clk_i);
    for (int i = 0; i < 40; i++) op(i);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
